// ### rtl/emb_defs.vh
// Shared constants of the external memory bus interface
`ifndef EMB_DEFS_VH
`define EMB_DEFS_VH

// ---------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------
`define EMB_MCU_SRE_BIT 7
`define EMB_MCU_UPW_LSB_BIT 6
`define EMB_CA_SECT_MSB 6
`define EMB_CA_SECT_LSB 4
`define EMB_CA_UPW_MSB_BIT 3
`define EMB_CA_LOW_MSB 1
`define EMB_CA_LOW_LSB 0
`define EMB_CB_KEEP_BIT 7
`define EMB_CB_HREL_MSB 2
`define EMB_CB_HREL_LSB 0

// ---------------------------------------------------------------
// Address map and timing
// ---------------------------------------------------------------
`define EMB_INT_TOP_NORMAL 16'h10ff
`define EMB_INT_TOP_COMPAT 16'h0fff
`define EMB_SECT_SHIFT 13
`define EMB_BASE_EXTRA 2'h1
`define EMB_RST_CTRL 8'h00

`endif

// ### rtl/emb_wait_sel.v
// Wait-state selection from sector boundary and configuration
`timescale 1ns/1ps
module emb_wait_sel (
    input wire [15:0] addr_i,
    input wire compat_i,
    input wire [7:0] mcu_ctrl_i,
    input wire [7:0] ctrl_a_i,
    output reg [1:0] wait_o
);
`include "emb_defs.vh"

    reg [2:0] sect_code;
    reg [1:0] upper_w;
    reg [1:0] lower_w;
    reg upper_hit;

    // Pick upper or lower sector wait count
    always @* begin
        sect_code = ctrl_a_i[`EMB_CA_SECT_MSB:`EMB_CA_SECT_LSB];
        upper_w = {ctrl_a_i[`EMB_CA_UPW_MSB_BIT], mcu_ctrl_i[`EMB_MCU_UPW_LSB_BIT]};
        lower_w = ctrl_a_i[`EMB_CA_LOW_MSB:`EMB_CA_LOW_LSB];
        // Code zero means one undivided region under the upper setting
        upper_hit = (sect_code == 3'h0) ||
                    (addr_i >= ({13'h0000, sect_code} << `EMB_SECT_SHIFT));
        if (compat_i) begin
            wait_o = {1'b0, mcu_ctrl_i[`EMB_MCU_UPW_LSB_BIT]};
        end else if (upper_hit) begin
            wait_o = upper_w;
        end else begin
            wait_o = lower_w;
        end
    end
endmodule // emb_wait_sel

// ### rtl/emb_keeper.v
// Bus-keeper holding the last level of the muxed data lines
`timescale 1ns/1ps
module emb_keeper #(
    parameter WIDTH = 8
) (
    input wire clk_i,
    input wire sys_rst_i,
    input wire enable_i,
    input wire float_i,
    input wire [WIDTH-1:0] pin_i,
    output reg [WIDTH-1:0] keep_val_o,
    output wire keep_oe_o
);

    // Track the level seen while the lines are driven
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            keep_val_o <= {WIDTH{1'b0}};
        end else if (!(enable_i && float_i)) begin
            keep_val_o <= pin_i;
        end
    end

    // Drive the held level only while nothing else drives
    assign keep_oe_o = enable_i && float_i;
endmodule // emb_keeper

// ### rtl/emb_top.v
// External memory bus interface: decode, strobe sequencing and pin override
`timescale 1ns/1ps
module emb_top (
    input wire clk_i,
    input wire sys_rst_i,
    // Configuration
    input wire compat_mode_i,
    input wire [7:0] mcu_ctrl_reg_i,
    input wire [7:0] ext_mem_ctrl_a_i,
    input wire [7:0] ext_mem_ctrl_b_i,
    // CPU data-space side
    input wire cpu_req_i,
    input wire cpu_we_i,
    input wire [15:0] cpu_addr_i,
    input wire [7:0] cpu_wdata_i,
    input wire cpu_next_ram_i,
    output wire cpu_stall_o,
    output wire cpu_int_sel_o,
    output reg cpu_done_o,
    output reg [7:0] cpu_rdata_o,
    // Ordinary port settings of the shared pins
    input wire [7:0] port_ad_out_i,
    input wire [7:0] port_ad_dir_i,
    input wire [7:0] port_ha_out_i,
    input wire [7:0] port_ha_dir_i,
    input wire [2:0] port_ctl_out_i,
    input wire [2:0] port_ctl_dir_i,
    // Pins
    input wire [7:0] muxed_low_addr_data_i,
    output reg [7:0] muxed_low_addr_data_o,
    output reg [7:0] muxed_low_addr_data_oe_o,
    output reg [7:0] high_addr_bus_o,
    output reg [7:0] high_addr_bus_oe_o,
    output reg ale_o,
    output reg ale_oe_o,
    output reg rd_n_o,
    output reg rd_n_oe_o,
    output reg wr_n_o,
    output reg wr_n_oe_o
);
`include "emb_defs.vh"

    // ---------------------------------------------------------------
    // States
    // ---------------------------------------------------------------
    localparam ST_IDLE = 2'h0;
    localparam ST_ADDR = 2'h1;
    localparam ST_STRB = 2'h2;

    // ---------------------------------------------------------------
    // Functions
    // ---------------------------------------------------------------
    // Pins kept by the bus for a given count of released high bits
    function [7:0] hi_keep_mask;
        input [2:0] rel;
        begin
            hi_keep_mask = 8'hff >> rel;
        end
    endfunction

    // Top of the internal data space for the active mode
    function [15:0] int_top;
        input compat;
        begin
            int_top = compat ? `EMB_INT_TOP_COMPAT : `EMB_INT_TOP_NORMAL;
        end
    endfunction

    // ---------------------------------------------------------------
    // Effective configuration
    // ---------------------------------------------------------------
    wire enable;
    wire [7:0] ctrl_a_eff;
    wire [7:0] ctrl_b_eff;
    wire keep_en;
    wire [7:0] ha_mask;
    wire is_ext;
    wire [1:0] wait_sel;

    // Enable bit in the MCU control register switches the bus on
    assign enable = mcu_ctrl_reg_i[`EMB_MCU_SRE_BIT];
    // Legacy mode hides both extended control registers
    assign ctrl_a_eff = compat_mode_i ? `EMB_RST_CTRL : ext_mem_ctrl_a_i;
    assign ctrl_b_eff = compat_mode_i ? `EMB_RST_CTRL : ext_mem_ctrl_b_i;
    assign keep_en = enable && ctrl_b_eff[`EMB_CB_KEEP_BIT];
    // Legacy mode forces all high address pins into use
    assign ha_mask = hi_keep_mask(ctrl_b_eff[`EMB_CB_HREL_MSB:`EMB_CB_HREL_LSB]);

    // Internal or external decision per address
    assign is_ext = cpu_addr_i > int_top(compat_mode_i);
    assign cpu_int_sel_o = cpu_req_i && !is_ext;

    emb_wait_sel u_wait_sel (
        .addr_i(cpu_addr_i),
        .compat_i(compat_mode_i),
        .mcu_ctrl_i(mcu_ctrl_reg_i),
        .ctrl_a_i(ctrl_a_eff),
        .wait_o(wait_sel)
    );

    // ---------------------------------------------------------------
    // Access sequencer
    // ---------------------------------------------------------------
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [1:0] cnt_r;
    reg [1:0] cnt_nxt;
    reg we_r;
    reg [7:0] wdata_r;
    reg [7:0] hi_addr_r;
    reg ale_r;
    reg rd_n_r;
    reg wr_n_r;
    reg ad_drv_r;
    reg [7:0] ad_val_r;
    wire ext_start;
    wire strb_last;
    wire take;
    wire strb_on;
    wire off_ext;

    assign ext_start = (state_r == ST_IDLE) && cpu_req_i && is_ext && enable;
    assign strb_last = (state_r == ST_STRB) && (cnt_r == 2'h0);
    // CPU waits from the request cycle until the last strobe cycle, which it sees unstalled
    assign cpu_stall_o = ext_start || ((state_r != ST_IDLE) && !strb_last);
    // Any request in idle while enabled opens an address cycle, internal ones too
    assign take = (state_r == ST_IDLE) && cpu_req_i && enable;
    // Cycles that lead into a strobe cycle: the address cycle and all but the last strobe
    assign strb_on = (state_r == ST_ADDR) || ((state_r == ST_STRB) && !strb_last);
    // High address with the bus switched off is answered at once, no alias
    assign off_ext = cpu_req_i && is_ext && !enable;

    // Access timing, W being the selected wait count:
    //   request cycle: stall raised, address and latch strobe registered
    //   address cycle: latch strobe high, low address on the muxed lines
    //   strobe cycles: W + 1 of them, read or write strobe low, latch strobe low
    //   following cycle: strobe high, done pulse, trailing latch pulse if asked
    //   internal access: address cycle only, read and write strobes stay high
    // The CPU sees W + 2 stall cycles per external byte; a new request may
    // follow in the cycle after the last strobe cycle.

    // Next state
    always @* begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
            ST_IDLE: begin
                if (ext_start) begin
                    state_nxt = ST_ADDR;
                    cnt_nxt = wait_sel;
                end
            end
            ST_ADDR: begin
                state_nxt = ST_STRB;
            end
            ST_STRB: begin
                // One base strobe cycle plus one per wait-state
                if (cnt_r == 2'h0) begin
                    state_nxt = ST_IDLE;
                end else begin
                    cnt_nxt = cnt_r - 2'h1;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // Sequencer registers
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_r <= ST_IDLE;
            cnt_r <= 2'h0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Request capture
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            we_r <= 1'b0;
            wdata_r <= 8'h00;
            hi_addr_r <= 8'h00;
        end else if (take) begin
            we_r <= cpu_we_i;
            wdata_r <= cpu_wdata_i;
            hi_addr_r <= cpu_addr_i[15:8];
        end
    end

    // Latch strobe: high in the address cycle, low through the transfer
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            ale_r <= 1'b0;
        end else if (take) begin
            // Internal accesses pulse it too; their strobes stay high
            ale_r <= 1'b1;
        end else if (strb_last) begin
            // Trailing pulse only when the next instruction touches RAM
            ale_r <= cpu_next_ram_i;
        end else begin
            ale_r <= 1'b0;
        end
    end

    // Read strobe: low only through the strobe cycles of an external read
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            rd_n_r <= 1'b1;
        end else if (strb_on) begin
            rd_n_r <= we_r;
        end else begin
            rd_n_r <= 1'b1;
        end
    end

    // Write strobe: low only through the strobe cycles of an external write
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            wr_n_r <= 1'b1;
        end else if (strb_on) begin
            wr_n_r <= !we_r;
        end else begin
            wr_n_r <= 1'b1;
        end
    end

    // Muxed bus drive: address first, then write data or release for reads
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            ad_drv_r <= 1'b0;
            ad_val_r <= 8'h00;
        end else if (take) begin
            ad_drv_r <= 1'b1;
            ad_val_r <= cpu_addr_i[7:0];
        end else if (strb_on) begin
            ad_drv_r <= we_r;
            ad_val_r <= we_r ? wdata_r : ad_val_r;
        end else begin
            ad_drv_r <= 1'b0;
        end
    end

    // Completion pulse after the last strobe cycle or an answered high access
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            cpu_done_o <= 1'b0;
        end else begin
            cpu_done_o <= strb_last || off_ext;
        end
    end

    // Read data: bus level in the last strobe cycle, zero with the bus off
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            cpu_rdata_o <= 8'h00;
        end else if (strb_last && !we_r) begin
            cpu_rdata_o <= muxed_low_addr_data_i;
        end else if (off_ext) begin
            cpu_rdata_o <= 8'h00;
        end
    end

    // ---------------------------------------------------------------
    // Bus-keeper
    // ---------------------------------------------------------------
    wire [7:0] keep_val;
    wire keep_oe;
    wire ad_float;

    // Lines float when the bus neither drives nor awaits read data
    // The keeper samples the pin, so it also holds the last read byte
    assign ad_float = !ad_drv_r && rd_n_r;

    emb_keeper #(
        .WIDTH(8)
    ) u_keeper (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .enable_i(keep_en),
        .float_i(ad_float),
        .pin_i(muxed_low_addr_data_i),
        .keep_val_o(keep_val),
        .keep_oe_o(keep_oe)
    );

    // ---------------------------------------------------------------
    // Pin override
    // ---------------------------------------------------------------
    // Muxed lines: bus or keeper level while enabled, port settings otherwise
    always @* begin
        if (enable) begin
            muxed_low_addr_data_oe_o = {8{ad_drv_r | keep_oe}};
            muxed_low_addr_data_o = ad_drv_r ? ad_val_r : keep_val;
        end else begin
            muxed_low_addr_data_oe_o = port_ad_dir_i;
            muxed_low_addr_data_o = port_ad_out_i;
        end
    end

    // High address: kept pins carry the address, released pins go to the port
    always @* begin
        if (enable) begin
            high_addr_bus_oe_o = ha_mask | (port_ha_dir_i & ~ha_mask);
            high_addr_bus_o = (hi_addr_r & ha_mask) | (port_ha_out_i & ~ha_mask);
        end else begin
            high_addr_bus_oe_o = port_ha_dir_i;
            high_addr_bus_o = port_ha_out_i;
        end
    end

    // Latch strobe pin: always an output while the bus is enabled
    always @* begin
        if (enable) begin
            ale_oe_o = 1'b1;
            ale_o = ale_r;
        end else begin
            ale_oe_o = port_ctl_dir_i[2];
            ale_o = port_ctl_out_i[2];
        end
    end

    // Read strobe pin: always an output while the bus is enabled
    always @* begin
        if (enable) begin
            rd_n_oe_o = 1'b1;
            rd_n_o = rd_n_r;
        end else begin
            rd_n_oe_o = port_ctl_dir_i[1];
            rd_n_o = port_ctl_out_i[1];
        end
    end

    // Write strobe pin: always an output while the bus is enabled
    always @* begin
        if (enable) begin
            wr_n_oe_o = 1'b1;
            wr_n_o = wr_n_r;
        end else begin
            wr_n_oe_o = port_ctl_dir_i[0];
            wr_n_o = port_ctl_out_i[0];
        end
    end
endmodule // emb_top

// ### tb/emb_top_assertions.sv
// Checker of the external memory bus interface pins
`timescale 1ns/1ps
`include "emb_defs.vh"
module emb_top_assertions (
    input wire clk_i,
    input wire sys_rst_i,
    input wire compat_mode_i,
    input wire [7:0] mcu_ctrl_reg_i,
    input wire [7:0] ext_mem_ctrl_a_i,
    input wire cpu_req_i,
    input wire [15:0] cpu_addr_i,
    input wire cpu_next_ram_i,
    input wire cpu_stall_o,
    input wire cpu_int_sel_o,
    input wire cpu_done_o,
    input wire [7:0] cpu_rdata_o,
    input wire [7:0] muxed_low_addr_data_o,
    input wire ale_o,
    input wire ale_oe_o,
    input wire rd_n_o,
    input wire rd_n_oe_o,
    input wire wr_n_o,
    input wire wr_n_oe_o
);
    // Internal top and wait count expected for the current address
    wire [15:0] top = compat_mode_i ? `EMB_INT_TOP_COMPAT : `EMB_INT_TOP_NORMAL;
    wire [2:0] sect = ext_mem_ctrl_a_i[6:4];
    wire upper = compat_mode_i || sect == 3'h0 || cpu_addr_i >= {sect, 13'h0000};
    wire [1:0] wsel = compat_mode_i ? {1'b0, mcu_ctrl_reg_i[6]} : upper ?
        {ext_mem_ctrl_a_i[3], mcu_ctrl_reg_i[6]} : ext_mem_ctrl_a_i[1:0];
    wire strb = !rd_n_o || !wr_n_o;
    reg stall_r;
    reg [1:0] wait_r;
    reg [2:0] low_r;
    // Wait count latched at the request, strobe-low cycles counted
    always @(posedge clk_i) begin
        stall_r <= sys_rst_i ? 1'b0 : cpu_stall_o;
        wait_r <= (cpu_stall_o && !stall_r) ? wsel : wait_r;
        low_r <= (sys_rst_i || !strb) ? 3'h0 : low_r + 3'h1;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    int_no_strobe_a: assert property (cpu_int_sel_o |=> (rd_n_o && wr_n_o) [*2])
        else $error("strobe during internal access");
    strobe_excl_a: assert property (!(!rd_n_o && !wr_n_o))
        else $error("read and write strobes together");
    ale_quiet_a: assert property (strb |-> !ale_o)
        else $error("latch strobe high during transfer");
    addr_latch_a: assert property ($rose(cpu_stall_o) |=>
        ale_o && muxed_low_addr_data_o == $past(cpu_addr_i[7:0]) ##1 !ale_o && strb)
        else $error("low address not valid at latch fall");
    strobe_len_a: assert property (($rose(rd_n_o) || $rose(wr_n_o)) |->
        low_r == {1'b0, wait_r} + 3'h1)
        else $error("strobe length differs from wait count");
    done_ale_a: assert property (($rose(rd_n_o) || $rose(wr_n_o)) |->
        cpu_done_o && ale_o == $past(cpu_next_ram_i))
        else $error("done or trailing latch pulse wrong");
    no_alias_a: assert property (cpu_req_i && !mcu_ctrl_reg_i[7] && cpu_addr_i > top |=>
        cpu_done_o && cpu_rdata_o == 8'h00)
        else $error("disabled high access aliased");
    int_decode_a: assert property (cpu_int_sel_o == (cpu_req_i && cpu_addr_i <= top))
        else $error("internal decode wrong");
    pin_own_a: assert property (mcu_ctrl_reg_i[7] |-> ale_oe_o && rd_n_oe_o && wr_n_oe_o)
        else $error("strobe pins not driven while enabled");
    // Main scenarios reached
    cover property ($rose(rd_n_o) && ale_o);
    cover property (low_r == 3'h4);
    cover property (cpu_int_sel_o && mcu_ctrl_reg_i[7]);
endmodule // emb_top_assertions

bind emb_top emb_top_assertions emb_top_assertions_i (
    .clk_i, .sys_rst_i, .compat_mode_i, .mcu_ctrl_reg_i, .ext_mem_ctrl_a_i, .cpu_req_i,
    .cpu_addr_i, .cpu_next_ram_i, .cpu_stall_o, .cpu_int_sel_o, .cpu_done_o, .cpu_rdata_o,
    .muxed_low_addr_data_o, .ale_o, .ale_oe_o, .rd_n_o, .rd_n_oe_o, .wr_n_o, .wr_n_oe_o
);

// ### tb/emb_sram_model.sv
// Behavioural external SRAM behind an address latch
`timescale 1ns/1ps
module emb_sram_model (
    input wire ale_i,
    input wire rd_n_i,
    input wire wr_n_i,
    input wire [7:0] ad_i,
    input wire [7:0] ha_i,
    input wire [7:0] dly_i,
    output wire [7:0] ad_o,
    output reg ad_oe_o
);
    reg [7:0] lo_r;
    reg [7:0] mem [0:65535];
    wire [15:0] addr = {ha_i, lo_r};
    // Bus level a moment back: the hold time of latch and memory
    wire [7:0] ad_hold;
    assign #1 ad_hold = ad_i;
    // Read data comes from the latched address
    assign ad_o = mem[addr];
    initial ad_oe_o = 1'b0;
    // Latch captures the low address as its strobe falls, within its hold time
    always @(negedge ale_i) lo_r = ad_hold;
    // Write takes the data as the write strobe rises, within its hold time
    always @(posedge wr_n_i) mem[addr] = ad_hold;
    // Data driven after the access delay, released with the strobe
    always @(negedge rd_n_i) begin
        #(dly_i);
        ad_oe_o = !rd_n_i;
    end
    always @(posedge rd_n_i) ad_oe_o = 1'b0;
endmodule // emb_sram_model

// ### tb/emb_top_tb_top.sv
// Self-checking testbench of the external memory bus interface
`timescale 1ns/1ps
module emb_top_tb_top;
    reg clk_i, sys_rst_i, compat_mode_i, cpu_req_i, cpu_we_i, cpu_next_ram_i;
    reg [7:0] mcu_ctrl_reg_i, ext_mem_ctrl_a_i, ext_mem_ctrl_b_i, cpu_wdata_i;
    reg [7:0] port_ha_dir_i, flt, dly;
    reg [15:0] cpu_addr_i;
    wire [7:0] port_ad_out_i = 8'h3c;
    wire [7:0] port_ad_dir_i = 8'h0f;
    wire [7:0] port_ha_out_i = 8'h00;
    wire [2:0] port_ctl_out_i = 3'h3;
    wire [2:0] port_ctl_dir_i = 3'h0;
    wire [7:0] cpu_rdata_o, muxed_low_addr_data_i, muxed_low_addr_data_o;
    wire [7:0] muxed_low_addr_data_oe_o, high_addr_bus_o, high_addr_bus_oe_o, ext_d;
    wire cpu_stall_o, cpu_int_sel_o, cpu_done_o, ale_o, ale_oe_o;
    wire rd_n_o, rd_n_oe_o, wr_n_o, wr_n_oe_o, ext_oe;
    integer failures, checked, t;
    emb_top emb_top_i (
        .clk_i, .sys_rst_i, .compat_mode_i, .mcu_ctrl_reg_i, .ext_mem_ctrl_a_i,
        .ext_mem_ctrl_b_i, .cpu_req_i, .cpu_we_i, .cpu_addr_i, .cpu_wdata_i, .cpu_next_ram_i,
        .cpu_stall_o, .cpu_int_sel_o, .cpu_done_o, .cpu_rdata_o, .port_ad_out_i,
        .port_ad_dir_i, .port_ha_out_i, .port_ha_dir_i, .port_ctl_out_i, .port_ctl_dir_i,
        .muxed_low_addr_data_i, .muxed_low_addr_data_o, .muxed_low_addr_data_oe_o,
        .high_addr_bus_o, .high_addr_bus_oe_o, .ale_o, .ale_oe_o, .rd_n_o, .rd_n_oe_o,
        .wr_n_o, .wr_n_oe_o
    );
    emb_sram_model emb_sram_model_i (
        .ale_i(ale_o), .rd_n_i(rd_n_o), .wr_n_i(wr_n_o), .ad_i(muxed_low_addr_data_i),
        .ha_i(high_addr_bus_o), .dly_i(dly), .ad_o(ext_d), .ad_oe_o(ext_oe)
    );
    // Bus level from both drivers; a released bus shows the inverse of its last level
    assign muxed_low_addr_data_i = (muxed_low_addr_data_oe_o & muxed_low_addr_data_o)
        | (~muxed_low_addr_data_oe_o & (ext_oe ? ext_d : flt));
    always @(posedge clk_i) flt <= ~muxed_low_addr_data_i;
    // Clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task stop_test;
        begin
            $display("checks %0d failures %0d", checked, failures);
            if (failures == 0 && checked > 0) $display("No errors found");
            else $display("Errors were found");
            $finish;
        end
    endtask
    task chk(input string n, input [31:0] e, input [31:0] g);
        begin
            checked = checked + 1;
            if (g !== e) begin
                failures = failures + 1;
                $display("[FAIL] %s expected %0h seen %0h", n, e, g);
            end
        end
    endtask
    task setc(input c, input [7:0] m, input [7:0] a, input [7:0] b, input n);
        begin
            @(negedge clk_i);
            compat_mode_i = c;
            mcu_ctrl_reg_i = m;
            ext_mem_ctrl_a_i = a;
            ext_mem_ctrl_b_i = b;
            cpu_next_ram_i = n;
        end
    endtask
    // One access: stall cycles, done and read data compared
    task acc(input we, input [15:0] a, input [7:0] d, input [3:0] hx, input xd,
        input [7:0] xr);
        integer k, hi, got;
        begin
            @(negedge clk_i);
            cpu_req_i = 1'b1;
            cpu_we_i = we;
            cpu_addr_i = a;
            cpu_wdata_i = d;
            hi = 0;
            got = 0;
            for (k = 0; k < 12 && got == 0; k = k + 1) begin
                @(negedge clk_i);
                if (cpu_stall_o === 1'b1) hi = hi + 1;
                else cpu_req_i = 1'b0;
                if (cpu_done_o === 1'b1) got = 1;
            end
            chk("stall cycles", hx, hi[31:0]);
            chk("done", xd, got[31:0]);
            if (!we && xd) chk("read data", xr, cpu_rdata_o);
        end
    endtask
    // Watchdog
    initial begin
        #50000;
        failures = failures + 1;
        stop_test;
    end
    initial begin
        failures = 0;
        checked = 0;
        sys_rst_i = 1'b1;
        {compat_mode_i, cpu_req_i, cpu_we_i, cpu_next_ram_i} = 4'h0;
        {mcu_ctrl_reg_i, ext_mem_ctrl_a_i, ext_mem_ctrl_b_i, cpu_wdata_i} = 32'h0;
        cpu_addr_i = 16'h0000;
        port_ha_dir_i = 8'h00;
        flt = 8'h00;
        dly = 8'h03;
        repeat (2) @(negedge clk_i);
        sys_rst_i = 1'b0;
        for (t = 0; t < 4; t = t + 1) begin
            setc(0, {1'b1, t[0], 6'h00}, {4'h0, t[1], 3'h0}, 8'h00, t[0]);
            acc(1, 16'h2000 + t[15:0], 8'h50 + t[7:0], t[3:0] + 4'h1, 1, 0);
            acc(0, 16'h2000 + t[15:0], 0, t[3:0] + 4'h1, 1, 8'h50 + t[7:0]);
        end
        $display("test wait states done");
        setc(0, 8'hc0, 8'h33, 8'h00, 0);
        acc(1, 16'h5fff, 8'h61, 4, 1, 0);
        acc(1, 16'h6000, 8'h62, 2, 1, 0);
        acc(0, 16'h5fff, 0, 4, 1, 8'h61);
        acc(0, 16'h10ff, 0, 0, 0, 0);
        acc(1, 16'h1100, 8'h77, 4, 1, 0);
        acc(0, 16'h1100, 0, 4, 1, 8'h77);
        $display("test sectors done");
        setc(1, 8'hc0, 8'hff, 8'h87, 1);
        acc(1, 16'h1000, 8'h99, 2, 1, 0);
        acc(1, 16'hf000, 8'h98, 2, 1, 0);
        setc(1, 8'h80, 8'hff, 8'h87, 0);
        acc(0, 16'h1000, 0, 1, 1, 8'h99);
        chk("legacy high oe", 8'hff, high_addr_bus_oe_o);
        chk("legacy idle oe", 8'h00, muxed_low_addr_data_oe_o);
        $display("test legacy done");
        setc(0, 8'hc0, 8'h33, 8'h83, 0);
        acc(1, 16'h6000, 8'ha5, 2, 1, 0);
        acc(0, 16'h6000, 0, 2, 1, 8'ha5);
        @(negedge clk_i);
        chk("released high oe", 8'h1f, high_addr_bus_oe_o);
        chk("keeper oe", 8'hff, muxed_low_addr_data_oe_o);
        chk("keeper level", 8'ha5, muxed_low_addr_data_i);
        $display("test keeper done");
        dly = 8'd25;
        setc(0, 8'h80, 8'h08, 8'h00, 0);
        acc(1, 16'h7000, 8'h3c, 3, 1, 0);
        acc(0, 16'h7000, 0, 3, 1, 8'h3c);
        $display("test slow device done");
        setc(0, 8'h00, 8'h00, 8'h00, 0);
        port_ha_dir_i = 8'h5a;
        @(negedge clk_i);
        chk("port ad oe", 8'h0f, muxed_low_addr_data_oe_o);
        chk("port ad out", 8'h3c, muxed_low_addr_data_o);
        chk("port high oe", 8'h5a, high_addr_bus_oe_o);
        acc(0, 16'h7000, 0, 0, 1, 8'h00);
        acc(1, 16'h7000, 8'hee, 0, 1, 0);
        setc(0, 8'h80, 8'h08, 8'h00, 0);
        acc(0, 16'h7000, 0, 3, 1, 8'h3c);
        $display("test disabled done");
        stop_test;
    end
endmodule // emb_top_tb_top
